// File: tb/gpio_expander_checker.sv
// Port-level assertions for the port and edge-interrupt block.
// Assumes one-cycle strobes on the register port; bound below.
`timescale 1ns/1ps
`default_nettype none
module gpio_expander_checker #(parameter int PINS = 8) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic [PINS-1:0] port_pin_in,
    input wire logic [PINS-1:0] port_pin_out,
    input wire logic [PINS-1:0] port_pin_oe_n,
    input wire logic edge_source_input,
    input wire logic other_irq_pending,
    input wire logic irq_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Request shapes on the register port
    sequence wr_s(a, d);
        reg_wr && reg_addr == a && reg_wdata == d;
    endsequence
    sequence rd_s(a);
        reg_rd && reg_addr == a;
    endsequence
    rvalid_follow_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read without rvalid");
    rvalid_pulse_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("stray rvalid");
    level_read_a: assert property (rd_s(8'h01) |=> reg_rdata == $past(port_pin_in))
        else $error("pin read wrong");
    unused_bits_a: assert property (rd_s(8'h08) |=> reg_rdata[4:0] == 5'h00)
        else $error("unused bits set");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");
    // Outputs land two edges after the write strobe
    low_push_a: assert property (wr_s(8'h00, 8'haa) |=> ##1 port_pin_oe_n[3:0] == 4'h0)
        else $error("push-pull not driven");
    high_input_a: assert property (wr_s(8'h07, 8'hff) |=> ##1 port_pin_oe_n[7:4] == 4'hf)
        else $error("input pins driven");
    level_drive_a: assert property (reg_wr && reg_addr == 8'h01 |=> ##1
        ((port_pin_out ^ $past(reg_wdata, 2)) & ~port_pin_oe_n) == 8'h00)
        else $error("driven level wrong");
    other_irq_a: assert property (other_irq_pending |=> !irq_n)
        else $error("irq_n not low");
endmodule
bind gpio_expander_edge_irq gpio_expander_checker #(.PINS(PINS)) gpio_expander_checker_inst (
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .port_pin_in(port_pin_in), .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
    .edge_source_input(edge_source_input), .other_irq_pending(other_irq_pending),
    .irq_n(irq_n));
`default_nettype wire

// File: tb/pin_partner.sv
// Far side of the port: pull-up on every pin plus an external driver.
// Assumes the block drives a pin only where its enable is low.
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    input wire logic [7:0] port_pin_out,
    input wire logic [7:0] port_pin_oe_n,
    input wire logic [7:0] ext_level,
    input wire logic ext_drive,
    output logic [7:0] pin_wire
);
    // Block wins where it drives, so a clash never hides a wrong enable
    always_comb begin
        pin_wire = ~port_pin_oe_n & port_pin_out | port_pin_oe_n & (ext_drive ? ext_level : 8'hff);
    end
endmodule
`default_nettype wire

// File: tb/test_gpio_expander_edge_irq.sv
// Register-level tests of the port and edge-interrupt block.
// Assumes the pin partner model resolves every pin level.
`timescale 1ns/1ps
`default_nettype none
module test_gpio_expander_edge_irq;
    logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid, edge_source_input, other_irq_pending;
    logic irq_n, ext_drive;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, port_pin_in, port_pin_out, port_pin_oe_n;
    int num_errors = 0;
    int n_compared = 0;
    logic [15:0] modes [5] = '{16'h0000, 16'h5555, 16'haaaa, 16'hffff, 16'he41b};
    // Edge steps: control, new pin level, flag expected
    logic [9:0] ev [6] = '{10'h103, 10'h100, 10'h182, 10'h181, 10'h082, 10'h000};
    gpio_expander_edge_irq gpio_expander_edge_irq_inst (.sys_clk(sys_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .port_pin_in(port_pin_in),
        .port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
        .edge_source_input(edge_source_input), .other_irq_pending(other_irq_pending),
        .irq_n(irq_n));
    pin_partner pin_partner_inst (.port_pin_out(port_pin_out), .port_pin_oe_n(port_pin_oe_n),
        .ext_level(8'h96), .ext_drive(ext_drive), .pin_wire(port_pin_in));
    always #2 sys_clk = ~sys_clk;
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge sys_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
        chk("rvalid", 8'h01, {7'h0, reg_rvalid});
    endtask
    // Expected enables: open drain drives only a low level
    function automatic logic [7:0] exp_oe(input logic [15:0] m, input logic [7:0] l);
        logic [7:0] oe;
        for (int i = 0; i < 8; i++) begin
            case (m[2*i +: 2])
                2'h0: oe[i] = l[i];
                2'h2: oe[i] = 1'b0;
                default: oe[i] = 1'b1;
            endcase
        end
        return oe;
    endfunction
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        test_done();
    end
    initial begin
        logic [7:0] d, oe;
        {sys_clk, rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b01, 18'h0};
        {edge_source_input, other_irq_pending, ext_drive} = 3'b000;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        // Unmapped places read as zero too
        for (int a = 0; a < 10; a++) begin
            rd(a[7:0], d);
            chk("reset", 8'h00, d);
        end
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            ext_drive = i[0];
            wr(8'h00, modes[i][7:0]);
            wr(8'h07, modes[i][15:8]);
            wr(8'h01, 8'h5a);
            @(negedge sys_clk);
            oe = exp_oe(modes[i], 8'h5a);
            chk("oe_n", oe, port_pin_oe_n);
            rd(8'h01, d);
            chk("pins", oe & (i[0] ? 8'h96 : 8'hff) | ~oe & 8'h5a, d);
        end
        $display("mode test done");
        for (int i = 0; i < 6; i++) begin
            wr(8'h08, ev[i][9:2] | 8'h9f);
            edge_source_input = ev[i][1];
            repeat (6) @(negedge sys_clk);
            chk("irq_n", {7'h0, ~ev[i][0]}, {7'h0, irq_n});
            rd(8'h08, d);
            chk("flag", {ev[i][0], ev[i][8:2]}, d);
            rd(8'h08, d);
            chk("cleared", ev[i][9:2], d);
            @(negedge sys_clk);
            chk("irq_n", 8'h01, {7'h0, irq_n});
        end
        other_irq_pending = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk("irq_n", 8'h00, {7'h0, irq_n});
        other_irq_pending = 1'b0;
        $display("edge test done");
        test_done();
    end
endmodule
`default_nettype wire

// File: verilog/gpio_expander_edge_irq.sv
// Eight-pin general-purpose port with one edge-triggered interrupt pin.
// Assumes a register front end (the serial host interface) that issues
// single-cycle read and write strobes with an 8-bit internal address.
//
// Contract
// - Eight port pins, each set as input or output by two mode registers.
// - Mode register at 0x00: two-bit field per pin 3..0; 00 OD, 01 in, 10 PP.
// - Pin 3 at bits 7-6, lower pins in lower pairs; pins 7..4 likewise.
// - Mode register at 0x07: pins 7..4; 11 also means input only.
// - Writing pin level drives each output pin low for 0; a 1 drives push-pull pins high and releases open-drain pins.
// - Reading pin level returns the live level of all eight pins.
// - Edge control bit 6 enables the edge pin as interrupt source.
// - Edge control bit 5: 0 rising edge, 1 falling edge triggers.
// - Selected edge while enabled sets edge control bit 7.
// - Enabled selected edge pulls the active-low interrupt output low.
// - A read of edge control clears the edge-detected flag, unless a new edge sets it in the same cycle.
// - Edge control bits 4 to 0 are unused and have no function.
// - All four registers reset to 0x00.
`timescale 1ns/1ps
`default_nettype none

module gpio_expander_edge_irq #(
    parameter int PINS = gpio_expander_pkg::PIN_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic [PINS-1:0] port_pin_in,
    output logic [PINS-1:0] port_pin_out,
    output logic [PINS-1:0] port_pin_oe_n,
    input wire logic edge_source_input,
    input wire logic other_irq_pending,
    output logic irq_n
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Mode field of pin p out of the two mode registers
    function automatic logic [1:0] pin_mode_field(input logic [7:0] low,
                                                  input logic [7:0] high,
                                                  input int p);
        logic [15:0] both;
        both = {high, low};
        return both[2*p +: 2];
    endfunction

    // Address match for a register access
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] port_mode_low_q;
    logic [7:0] port_mode_high_q;
    logic [7:0] pin_level_q;
    logic edge_irq_enable_q;
    logic edge_polarity_select_q;
    logic edge_detected_flag_q;
    logic edge_sync1_q;
    logic edge_sync2_q;
    logic edge_prev_q;
    logic edge_hit;
    logic flag_clear;
    logic [PINS-1:0] pin_out_d;
    logic [PINS-1:0] pin_oe_n_d;
    logic [7:0] rdata_d;

    // Mode registers, written by the host
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_mode_low_q <= gpio_expander_pkg::RST_PORT_MODE_LOW;
            port_mode_high_q <= gpio_expander_pkg::RST_PORT_MODE_HIGH;
        end else if (reg_wr) begin
            if (hit(reg_addr, gpio_expander_pkg::ADDR_PORT_MODE_LOW)) begin
                port_mode_low_q <= reg_wdata;
            end
            if (hit(reg_addr, gpio_expander_pkg::ADDR_PORT_MODE_HIGH)) begin
                port_mode_high_q <= reg_wdata;
            end
        end
    end

    // Output level register; inputs keep the stored level for later
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pin_level_q <= gpio_expander_pkg::RST_PIN_LEVEL;
        end else if (reg_wr && hit(reg_addr, gpio_expander_pkg::ADDR_PIN_LEVEL)) begin
            pin_level_q <= reg_wdata;
        end
    end

    // Edge control fields; bits 4..0 are not stored at all
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_irq_enable_q <= gpio_expander_pkg::RST_EDGE_IRQ_CONTROL[gpio_expander_pkg::EDGE_IRQ_ENABLE_BIT];
            edge_polarity_select_q <= gpio_expander_pkg::RST_EDGE_IRQ_CONTROL[gpio_expander_pkg::EDGE_POLARITY_SELECT_BIT];
        end else if (reg_wr && hit(reg_addr, gpio_expander_pkg::ADDR_EDGE_IRQ_CONTROL)) begin
            edge_irq_enable_q <= reg_wdata[gpio_expander_pkg::EDGE_IRQ_ENABLE_BIT];
            edge_polarity_select_q <= reg_wdata[gpio_expander_pkg::EDGE_POLARITY_SELECT_BIT];
        end
    end

    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------

    // Open drain only pulls low, so a 1 releases the pin to the pull-up
    always_comb begin
        for (int p = 0; p < PINS; p++) begin
            case (pin_mode_field(port_mode_low_q, port_mode_high_q, p))
                gpio_expander_pkg::MODE_OPEN_DRAIN: begin
                    pin_out_d[p] = 1'b0;
                    pin_oe_n_d[p] = pin_level_q[p];
                end
                gpio_expander_pkg::MODE_PUSH_PULL: begin
                    pin_out_d[p] = pin_level_q[p];
                    pin_oe_n_d[p] = 1'b0;
                end
                default: begin
                    // Input only, and the spare code treated the same way
                    pin_out_d[p] = 1'b0;
                    pin_oe_n_d[p] = 1'b1;
                end
            endcase
        end
    end

    // Registered pin drive; released during reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port_pin_out <= '0;
            port_pin_oe_n <= '1;
        end else begin
            port_pin_out <= pin_out_d;
            port_pin_oe_n <= pin_oe_n_d;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------

    // Two flops against metastability, a third for the previous level
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_sync1_q <= 1'b0;
            edge_sync2_q <= 1'b0;
            edge_prev_q <= 1'b0;
        end else begin
            edge_sync1_q <= edge_source_input;
            edge_sync2_q <= edge_sync1_q;
            edge_prev_q <= edge_sync2_q;
        end
    end

    // Qualifying transition, only on synchronised levels
    assign edge_hit = edge_irq_enable_q && (edge_polarity_select_q ?
                      (edge_prev_q && !edge_sync2_q) :
                      (!edge_prev_q && edge_sync2_q));
    assign flag_clear = reg_rd && hit(reg_addr, gpio_expander_pkg::ADDR_EDGE_IRQ_CONTROL);

    // Sticky flag; a new edge beats a clearing read in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            edge_detected_flag_q <= gpio_expander_pkg::RST_EDGE_IRQ_CONTROL[gpio_expander_pkg::EDGE_DETECTED_FLAG_BIT];
        end else if (edge_hit) begin
            edge_detected_flag_q <= 1'b1;
        end else if (flag_clear) begin
            edge_detected_flag_q <= 1'b0;
        end
    end

    // Interrupt output, shared with the device's other sources
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= !(edge_detected_flag_q || other_irq_pending);
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Read mux; unmapped addresses answer zero
    always_comb begin
        rdata_d = 8'h00;
        case (reg_addr)
            gpio_expander_pkg::ADDR_PORT_MODE_LOW: rdata_d = port_mode_low_q;
            gpio_expander_pkg::ADDR_PORT_MODE_HIGH: rdata_d = port_mode_high_q;
            gpio_expander_pkg::ADDR_PIN_LEVEL: begin
                rdata_d[PINS-1:0] = port_pin_in;
            end
            gpio_expander_pkg::ADDR_EDGE_IRQ_CONTROL: begin
                rdata_d[gpio_expander_pkg::EDGE_DETECTED_FLAG_BIT] = edge_detected_flag_q;
                rdata_d[gpio_expander_pkg::EDGE_IRQ_ENABLE_BIT] = edge_irq_enable_q;
                rdata_d[gpio_expander_pkg::EDGE_POLARITY_SELECT_BIT] = edge_polarity_select_q;
                // Bits 4..0 read as zero
                rdata_d[4:0] = 5'h00;
            end
            default: rdata_d = 8'h00;
        endcase
    end

    // Registered read answer, one cycle after the strobe
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= rdata_d;
            end
        end
    end

endmodule

`default_nettype wire

// File: verilog/gpio_expander_pkg.sv
// Package for the eight-pin port and edge-interrupt block.
// Assumes the register front end presents 8-bit internal addresses.
package gpio_expander_pkg;

    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_PORT_MODE_LOW = 8'h00;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h01;
    localparam logic [7:0] ADDR_PORT_MODE_HIGH = 8'h07;
    localparam logic [7:0] ADDR_EDGE_IRQ_CONTROL = 8'h08;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_PORT_MODE_LOW = 8'h00;
    localparam logic [7:0] RST_PIN_LEVEL = 8'h00;
    localparam logic [7:0] RST_PORT_MODE_HIGH = 8'h00;
    localparam logic [7:0] RST_EDGE_IRQ_CONTROL = 8'h00;

    // ------------------------------------------------------------
    // Edge control field positions
    // ------------------------------------------------------------
    localparam int EDGE_DETECTED_FLAG_BIT = 7;
    localparam int EDGE_IRQ_ENABLE_BIT = 6;
    localparam int EDGE_POLARITY_SELECT_BIT = 5;

    // ------------------------------------------------------------
    // Pin mode encodings
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h0;
    localparam logic [1:0] MODE_INPUT = 2'h1;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h2;
    localparam logic [1:0] MODE_SPARE = 2'h3;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int PIN_COUNT = 8;
    localparam int PINS_PER_MODE_REG = 4;

endpackage
